// *** hw/program_flow_trace_reporter.sv ***
// What this block does
// - Indirect flow events mark the target fetch
// - Internal marked fetch drives direction low
// - External marked fetch shows cycle type 0001
// - Marked cycles flag instruction address type
// - Internal show cycles use internal type codes
// - External full cycles, internal address-only
// - Context instructions report 101, mark next
// - Control 00/01/10 pick shown fetch classes
// - Control 11 shows indirect only with sync
// - New control applies from second fetch
// - Sync request comes only from serial port
// - Sync change forces sync; marks next fetch except in a flush slot
// - History flush count every clock
// - Flush counts only when no type info
// - Codes 000-011 precede more type info
// - Codes 100-111 precede flush info
// - Flush counts 0-5, never 110
// - Only 111 may replace flush info
// - History code 11 means debug mode
// - Debug mode holds 000 and 11
`timescale 1ns/1ns
module program_flow_trace_reporter
(
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic reset,
    input wire logic ce,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Core fetch report
    input wire logic fetch_valid,
    input wire trace_pkg::fetch_kind_t fetch_kind,
    input wire logic [2:0] queue_flush_count,
    input wire logic [1:0] hist_flush_count,
    input wire logic debug_mode,
    // Serial development port
    input wire logic sync_request,
    output logic sync_force,
    // Fetch bus cycle from bus unit
    input wire logic bus_fetch_valid,
    input wire logic bus_fetch_external,
    input wire logic [3:0] bus_region_code,
    // Trace pins
    output logic [2:0] fetch_type_status,
    output logic [1:0] hist_flush_status,
    output logic show_cycle,
    output logic show_addr_only,
    output logic [3:0] cycle_type_code,
    output logic addr_type_instr,
    output logic transfer_direction_n
);
    import trace_pkg::*;

    typedef enum logic {SLOT_TYPE, SLOT_FLUSH} slot_t;

    trace_attr_if attr ();

    slot_t slot;
    slot_t next_slot;
    logic sync_prev;
    logic sync_toggle;
    logic exit_pending;
    logic exit_sync;
    logic debug_prev;
    logic held_valid;
    fetch_kind_t held_kind;
    logic [2:0] flush_acc;
    logic [2:0] flush_sum;
    logic [3:0] flush_wide;
    logic mark_icof;
    logic mark_cof;
    logic [2:0] next_code;
    logic emit_type;
    logic take_fetch;
    logic [15:0] show_count;

    function automatic logic [2:0] type_code(input fetch_kind_t k);
        case (k)
            FK_SEQ: type_code = FT_SEQ;
            FK_NOT_TAKEN: type_code = FT_NOT_TAKEN;
            FK_DIRECT: type_code = FT_DIRECT;
            FK_INDIRECT: type_code = FT_INDIRECT;
            FK_CONTEXT: type_code = FT_INDIRECT;
            FK_EXCEPTION: type_code = FT_EXCEPTION;
            default: type_code = FT_NONE;
        endcase
    endfunction

    // Codes that make the following fetch an indirect-flow target
    function automatic logic marks_icof(input logic [2:0] c);
        marks_icof = c == FT_SYNC || c == FT_EXCEPTION || c == FT_INDIRECT;
    endfunction

    // only the serial port path changes it
    assign sync_toggle = sync_request != sync_prev;

    always_comb
    begin
        flush_wide = {1'b0, flush_acc} + {1'b0, queue_flush_count};
        // saturate, never reserved; carry kept so 4+4 cannot wrap
        if (flush_wide > {1'b0, FLUSH_MAX})
            flush_sum = FLUSH_MAX;
        else
            flush_sum = flush_wide[2:0];
    end

    // Sequencing of the shared status bus
    always_comb
    begin
        next_code = FT_NONE;
        next_slot = slot;
        emit_type = 1'b0;
        take_fetch = 1'b0;
        if (debug_mode)
            next_code = FT_NONE;
        else if (slot == SLOT_FLUSH)
        begin
            if (fetch_valid && !held_valid && fetch_kind == FK_NOT_TAKEN
                && !exit_pending && !sync_toggle)
            begin
                next_code = FT_NOT_TAKEN_SLOT;
                emit_type = 1'b1;
                take_fetch = 1'b1;
            end
            // flush count in a no-type cycle
            else
            begin
                next_code = flush_sum;
                next_slot = SLOT_TYPE;
            end
        end
        else
        begin
            emit_type = 1'b1;
            if (exit_pending)
                next_code = exit_sync ? FT_SYNC : FT_INDIRECT;
            else if (sync_toggle)
                next_code = FT_SYNC;
            else if (held_valid)
                next_code = type_code(held_kind);
            else if (fetch_valid)
            begin
                next_code = type_code(fetch_kind);
                take_fetch = 1'b1;
            end
            next_slot = next_code[2] ? SLOT_FLUSH : SLOT_TYPE;
        end
    end

    always_ff @(posedge core_clk or posedge reset)
        if (reset)
        begin
            fetch_type_status <= FT_NONE;
            hist_flush_status <= 2'h0;
            slot <= SLOT_TYPE;
        end
        else if (ce)
        begin
            fetch_type_status <= next_code;
            slot <= debug_mode ? SLOT_TYPE : next_slot;
            if (debug_mode)
                hist_flush_status <= HIST_DEBUG;
            else if (hist_flush_count > HIST_MAX)
                hist_flush_status <= HIST_MAX;
            else
                hist_flush_status <= hist_flush_count;
        end

    // A fetch that loses the bus to another report waits one entry deep
    always_ff @(posedge core_clk or posedge reset)
        if (reset)
        begin
            held_valid <= 1'b0;
            held_kind <= FK_NONE;
        end
        else if (ce && !debug_mode)
        begin
            if (fetch_valid && !take_fetch)
            begin
                held_valid <= 1'b1;
                held_kind <= fetch_kind;
            end
            else if (slot == SLOT_TYPE && !exit_pending && !sync_toggle)
                held_valid <= 1'b0;
        end

    // Queue flushes wait for the flush slot
    always_ff @(posedge core_clk or posedge reset)
        if (reset)
            flush_acc <= 3'h0;
        else if (ce)
        begin
            if (debug_mode || (slot == SLOT_FLUSH && !emit_type))
                flush_acc <= 3'h0;
            else
                flush_acc <= flush_sum;
        end

    always_ff @(posedge core_clk or posedge reset)
        if (reset)
        begin
            sync_prev <= 1'b0;
            sync_force <= 1'b0;
        end
        else if (ce)
        begin
            sync_prev <= sync_request;
            sync_force <= sync_toggle;
        end

    // Leaving debug reports a sync change or the return as indirect
    always_ff @(posedge core_clk or posedge reset)
        if (reset)
        begin
            debug_prev <= 1'b0;
            exit_pending <= 1'b0;
            exit_sync <= 1'b0;
        end
        else if (ce)
        begin
            debug_prev <= debug_mode;
            if (debug_mode)
            begin
                if (sync_toggle)
                    exit_sync <= 1'b1;
            end
            else if (debug_prev)
                exit_pending <= 1'b1;
            else if (slot == SLOT_TYPE)
            begin
                exit_pending <= 1'b0;
                exit_sync <= 1'b0;
            end
        end

    // mark the next bus fetch; a new mark wins over its use
    always_ff @(posedge core_clk or posedge reset)
        if (reset)
        begin
            mark_icof <= 1'b0;
            mark_cof <= 1'b0;
        end
        else if (ce)
        begin
            if (emit_type && marks_icof(next_code))
                mark_icof <= 1'b1;
            else if (bus_fetch_valid)
                mark_icof <= 1'b0;
            if (emit_type && next_code == FT_DIRECT)
                mark_cof <= 1'b1;
            else if (bus_fetch_valid)
                mark_cof <= 1'b0;
        end

    assign attr.fetch_valid = bus_fetch_valid;
    assign attr.icof = mark_icof;
    assign attr.cof = mark_cof;
    assign attr.external = bus_fetch_external;
    assign attr.region_code = bus_region_code;
    assign attr.sync_level = sync_request;
    assign attr.ctl_write = reg_write && reg_addr == REG_SHOW_CTL;
    assign attr.ctl_wdata = reg_wdata[1:0];

    fetch_show_filter u_filter (
        .core_clk(core_clk),
        .reset(reset),
        .ce(ce),
        .attr(attr)
    );

    bus_attr_marker u_marker (
        .core_clk(core_clk),
        .reset(reset),
        .attr(attr)
    );

    always_ff @(posedge core_clk or posedge reset)
        if (reset)
        begin
            show_cycle <= 1'b0;
            show_addr_only <= 1'b0;
            cycle_type_code <= CT_EXTERNAL;
            addr_type_instr <= 1'b0;
            transfer_direction_n <= 1'b1;
        end
        else if (ce)
        begin
            show_cycle <= attr.show;
            show_addr_only <= attr.show && attr.addr_only;
            cycle_type_code <= attr.show ? attr.cycle_code : CT_EXTERNAL;
            addr_type_instr <= attr.show && attr.at1;
            transfer_direction_n <= attr.show ? attr.wr_n : 1'b1;
        end

    // Show cycle tally, cleared by a write
    always_ff @(posedge core_clk or posedge reset)
        if (reset)
            show_count <= SHOW_COUNT_RESET;
        else if (ce)
        begin
            if (reg_write && reg_addr == REG_SHOW_COUNT)
                show_count <= SHOW_COUNT_RESET;
            else if (attr.show)
                show_count <= show_count + 16'h0001;
        end

    always_ff @(posedge core_clk or posedge reset)
        if (reset)
            reg_rdata <= 32'h0000_0000;
        else if (ce)
        begin
            reg_rdata <= 32'h0000_0000;
            if (reg_read)
                case (reg_addr)
                    REG_SHOW_CTL: reg_rdata[1:0] <= attr.pend_ctl;
                    REG_STATUS: reg_rdata[5:0] <= {slot == SLOT_FLUSH,
                        attr.lag_pending, debug_mode, sync_request,
                        attr.eff_ctl};
                    REG_SHOW_COUNT: reg_rdata[15:0] <= show_count;
                    default: reg_rdata <= 32'h0000_0000;
                endcase
        end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    property p_debug_hold;
        ce && debug_mode |=> fetch_type_status == FT_NONE
            && hist_flush_status == HIST_DEBUG;
    endproperty
    a_debug_hold: assert property (p_debug_hold)
        else $error("debug mode status values wrong");

    property p_no_reserved;
        ce && !debug_mode && slot == SLOT_FLUSH |=>
            fetch_type_status != FLUSH_RESERVED;
    endproperty
    a_no_reserved: assert property (p_no_reserved)
        else $error("reserved flush code output");

    property p_only_111;
        ce && !debug_mode && slot == SLOT_FLUSH && emit_type
            |=> fetch_type_status == FT_NOT_TAKEN_SLOT;
    endproperty
    a_only_111: assert property (p_only_111)
        else $error("type other than 111 in flush slot");

    property p_flush_follows;
        ce && !debug_mode && emit_type && next_code[2] |=> slot == SLOT_FLUSH;
    endproperty
    a_flush_follows: assert property (p_flush_follows)
        else $error("flush slot not opened after taken code");

    sequence s_sync_seen;
        ce && !debug_mode && slot == SLOT_TYPE && sync_toggle
            && !exit_pending;
    endsequence
    sequence s_sync_reported;
        fetch_type_status == FT_SYNC && sync_force && mark_icof;
    endsequence
    property p_sync_mark;
        s_sync_seen |=> s_sync_reported;
    endproperty
    a_sync_mark: assert property (p_sync_mark)
        else $error("sync change not reported and marked");
endmodule

// *** hw/trace_pkg.sv ***
package trace_pkg;

    // What the core reports about the instruction it just fetched
    typedef enum logic [2:0] {
        FK_NONE,
        FK_SEQ,
        FK_NOT_TAKEN,
        FK_DIRECT,
        FK_INDIRECT,
        FK_EXCEPTION,
        FK_CONTEXT
    } fetch_kind_t;

    // Fetch-type codes on fetch_type_status
    localparam logic [2:0] FT_NONE = 3'h0;
    localparam logic [2:0] FT_SEQ = 3'h1;
    localparam logic [2:0] FT_NOT_TAKEN = 3'h2;
    localparam logic [2:0] FT_SYNC = 3'h3;
    localparam logic [2:0] FT_EXCEPTION = 3'h4;
    localparam logic [2:0] FT_INDIRECT = 3'h5;
    localparam logic [2:0] FT_DIRECT = 3'h6;
    localparam logic [2:0] FT_NOT_TAKEN_SLOT = 3'h7;
    localparam logic [2:0] FLUSH_MAX = 3'h5;
    localparam logic [2:0] FLUSH_RESERVED = 3'h6;

    // History flush codes
    localparam logic [1:0] HIST_MAX = 2'h2;
    localparam logic [1:0] HIST_DEBUG = 2'h3;

    // Show-cycle control settings
    localparam logic [1:0] SHOW_ALL = 2'h0;
    localparam logic [1:0] SHOW_ALL_COF = 2'h1;
    localparam logic [1:0] SHOW_INDIRECT = 2'h2;
    localparam logic [1:0] SHOW_SYNC_ONLY = 2'h3;
    localparam logic [1:0] SHOW_CTL_RESET = 2'h0;

    // Cycle type codes
    localparam logic [3:0] CT_EXTERNAL = 4'h0;
    localparam logic [3:0] CT_EXT_ICOF = 4'h1;
    localparam logic [3:0] CT_INT_DEFAULT = 4'h4;

    // Register map
    localparam logic [7:0] REG_SHOW_CTL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_SHOW_COUNT = 8'h08;
    localparam logic [15:0] SHOW_COUNT_RESET = 16'h0000;

endpackage

// *** hw/trace_attr_if.sv ***
`timescale 1ns/1ns
interface trace_attr_if;
    import trace_pkg::*;
    logic fetch_valid;
    logic icof;
    logic cof;
    logic external;
    logic [3:0] region_code;
    logic sync_level;
    logic ctl_write;
    logic [1:0] ctl_wdata;
    logic [1:0] eff_ctl;
    logic [1:0] pend_ctl;
    logic lag_pending;
    logic show;
    logic addr_only;
    logic [3:0] cycle_code;
    logic at1;
    logic wr_n;

    modport main (output fetch_valid, icof, cof, external, region_code,
        sync_level, ctl_write, ctl_wdata, input eff_ctl, pend_ctl,
        lag_pending, show, addr_only, cycle_code, at1, wr_n);
    modport filter (input fetch_valid, icof, cof, sync_level, ctl_write,
        ctl_wdata, output eff_ctl, pend_ctl, lag_pending, show);
    modport marker (input fetch_valid, icof, external, region_code,
        output addr_only, cycle_code, at1, wr_n);
endinterface

// *** hw/fetch_show_filter.sv ***
`timescale 1ns/1ns
module fetch_show_filter
(
    // Clock, reset and enable
    input wire logic core_clk,
    input wire logic reset,
    input wire logic ce,
    // Attributes of the current fetch
    trace_attr_if.filter attr
);
    import trace_pkg::*;

    // old setting for one more fetch
    always_ff @(posedge core_clk or posedge reset)
        if (reset)
        begin
            attr.eff_ctl <= SHOW_CTL_RESET;
            attr.pend_ctl <= SHOW_CTL_RESET;
            attr.lag_pending <= 1'b0;
        end
        else if (ce)
        begin
            if (attr.ctl_write)
            begin
                attr.pend_ctl <= attr.ctl_wdata;
                attr.lag_pending <= 1'b1;
            end
            else if (attr.lag_pending && attr.fetch_valid)
            begin
                attr.eff_ctl <= attr.pend_ctl;
                attr.lag_pending <= 1'b0;
            end
        end

    always_comb
        case (attr.eff_ctl)
            SHOW_ALL: attr.show = attr.fetch_valid;
            SHOW_ALL_COF: attr.show = attr.fetch_valid
                && (attr.cof || attr.icof);
            SHOW_INDIRECT: attr.show = attr.fetch_valid && attr.icof;
            SHOW_SYNC_ONLY: attr.show = attr.fetch_valid && attr.icof
                && attr.sync_level;
            default: attr.show = 1'b0;
        endcase

    property p_sync_off_quiet;
        @(posedge core_clk) disable iff (reset)
        attr.eff_ctl == SHOW_SYNC_ONLY && !attr.sync_level |-> !attr.show;
    endproperty
    a_sync_off_quiet: assert property (p_sync_off_quiet)
        else $error("show cycle with sync request negated");

    property p_indirect_shown;
        @(posedge core_clk) disable iff (reset)
        attr.fetch_valid && attr.icof && attr.eff_ctl != SHOW_SYNC_ONLY
            |-> attr.show;
    endproperty
    a_indirect_shown: assert property (p_indirect_shown)
        else $error("indirect change of flow not shown");
endmodule

// *** hw/bus_attr_marker.sv ***
`timescale 1ns/1ns
module bus_attr_marker
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Attributes of the current fetch
    trace_attr_if.marker attr
);
    import trace_pkg::*;

    // Internal codes outside 01xx/10xx/110x would hide the mark
    function automatic logic code_ok(input logic [3:0] c);
        code_ok = (c[3] ^ c[2]) || (c[3:1] == 3'b110);
    endfunction

    logic [3:0] int_code;
    assign int_code = code_ok(attr.region_code) ? attr.region_code
        : CT_INT_DEFAULT;

    assign attr.addr_only = !attr.external;
    assign attr.at1 = attr.fetch_valid;
    assign attr.cycle_code = !attr.external ? int_code
        : (attr.icof ? CT_EXT_ICOF : CT_EXTERNAL);
    assign attr.wr_n = !(attr.fetch_valid && attr.icof && !attr.external);

    property p_at1;
        @(posedge core_clk) disable iff (reset)
        attr.fetch_valid && attr.icof |-> attr.at1;
    endproperty
    a_at1: assert property (p_at1)
        else $error("marked fetch without instruction type");

    property p_ext_code;
        @(posedge core_clk) disable iff (reset)
        attr.fetch_valid && attr.icof && attr.external
            |-> attr.cycle_code == CT_EXT_ICOF && attr.wr_n;
    endproperty
    a_ext_code: assert property (p_ext_code)
        else $error("external marked fetch lacks code 0001");

    property p_int_mark;
        @(posedge core_clk) disable iff (reset)
        attr.fetch_valid && attr.icof && !attr.external
            |-> !attr.wr_n && code_ok(attr.cycle_code);
    endproperty
    a_int_mark: assert property (p_int_mark)
        else $error("internal marked fetch lacks low direction");

    property p_int_code;
        @(posedge core_clk) disable iff (reset)
        !attr.external |-> code_ok(attr.cycle_code);
    endproperty
    a_int_code: assert property (p_int_code)
        else $error("internal show cycle with bad cycle type");
endmodule

// *** tb/trace_capture_model.sv ***
`timescale 1ns/1ns
module trace_capture_model
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Trace pins
    input wire logic [2:0] fetch_type_status,
    input wire logic [1:0] hist_flush_status,
    // Decoded flush information
    output logic flush_slot,
    output logic [2:0] last_flush
);
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            flush_slot <= 1'b0;
            last_flush <= 3'h0;
        end
        else if (hist_flush_status != 2'h3)
        begin
            if (flush_slot && fetch_type_status != 3'h7)
            begin
                last_flush <= fetch_type_status;
                flush_slot <= 1'b0;
            end
            else
            begin
                flush_slot <= fetch_type_status[2];
            end
        end
    end
endmodule

// *** tb/program_flow_trace_reporter_tb_top.sv ***
`timescale 1ns/1ns
module program_flow_trace_reporter_tb_top;
    import trace_pkg::*;
    logic core_clk, reset, ce, reg_write, reg_read, fetch_valid;
    logic debug_mode, sync_request, sync_force, bus_fetch_valid;
    logic bus_fetch_external, show_cycle, show_addr_only;
    logic addr_type_instr, transfer_direction_n, flush_slot;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    fetch_kind_t fetch_kind;
    logic [2:0] queue_flush_count, fetch_type_status, last_flush;
    logic [1:0] hist_flush_count, hist_flush_status;
    logic [3:0] bus_region_code, cycle_type_code;
    int n_fail, cmp_count;

    program_flow_trace_reporter uut (
        .core_clk(core_clk), .reset(reset), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .fetch_valid(fetch_valid),
        .fetch_kind(fetch_kind), .queue_flush_count(queue_flush_count),
        .hist_flush_count(hist_flush_count), .debug_mode(debug_mode),
        .sync_request(sync_request), .sync_force(sync_force),
        .bus_fetch_valid(bus_fetch_valid),
        .bus_fetch_external(bus_fetch_external),
        .bus_region_code(bus_region_code),
        .fetch_type_status(fetch_type_status),
        .hist_flush_status(hist_flush_status),
        .show_cycle(show_cycle), .show_addr_only(show_addr_only),
        .cycle_type_code(cycle_type_code),
        .addr_type_instr(addr_type_instr),
        .transfer_direction_n(transfer_direction_n));

    trace_capture_model capture (
        .core_clk(core_clk), .reset(reset),
        .fetch_type_status(fetch_type_status),
        .hist_flush_status(hist_flush_status),
        .flush_slot(flush_slot), .last_flush(last_flush));

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task complete_run;
        if (n_fail == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", name, e, g);
        end
    endtask

    task ft(input logic [2:0] e);
        chk("fetch_type_status", {29'h0, e}, {29'h0, fetch_type_status});
    endtask

    // Packed as show, addr-only, type code, instr, direction
    task pins(input logic [7:0] e);
        chk("show pins", {24'h0, e}, {24'h0, show_cycle, show_addr_only,
            cycle_type_code, addr_type_instr, transfer_direction_n});
    endtask

    task quiet;
        fetch_valid <= 1'b0;
        bus_fetch_valid <= 1'b0;
    endtask

    task cyc(input logic fv, input fetch_kind_t k, input logic [2:0] q,
        input logic bfv, input logic bext, input logic [3:0] rc);
        @(posedge core_clk);
        fetch_valid <= fv;
        fetch_kind <= k;
        queue_flush_count <= q;
        bus_fetch_valid <= bfv;
        bus_fetch_external <= bext;
        bus_region_code <= rc;
        #1;
    endtask

    task idle;
        cyc(1'b0, FK_NONE, 3'h0, 1'b0, 1'b0, 4'h4);
    endtask

    task fetch(input fetch_kind_t k);
        cyc(1'b1, k, 3'h0, 1'b0, 1'b0, 4'h4);
    endtask

    task bus(input logic ext, input logic [3:0] rc);
        cyc(1'b0, FK_NONE, 3'h0, 1'b1, ext, rc);
    endtask

    // Sync level is what the serial port hands over
    task side(input logic [1:0] h, input logic d, input logic s);
        @(posedge core_clk);
        quiet;
        hist_flush_count <= h;
        debug_mode <= d;
        sync_request <= s;
        #1;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        quiet;
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_write <= 1'b0;
        #1;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e, input string name);
        @(posedge core_clk);
        quiet;
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1;
        chk(name, e, reg_rdata);
    endtask

    initial
    begin
        repeat (2000) @(posedge core_clk);
        n_fail++;
        complete_run;
    end

    initial
    begin
        n_fail = 0;
        cmp_count = 0;
        reset = 1'b1;
        ce = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_write = 1'b0;
        reg_read = 1'b0;
        fetch_valid = 1'b0;
        fetch_kind = FK_NONE;
        queue_flush_count = 3'h0;
        hist_flush_count = 2'h0;
        debug_mode = 1'b0;
        sync_request = 1'b0;
        bus_fetch_valid = 1'b0;
        bus_fetch_external = 1'b0;
        bus_region_code = 4'h4;
        repeat (20) @(posedge core_clk);
        #1;
        ft(FT_NONE);
        pins(8'h01);
        @(posedge core_clk);
        reset <= 1'b0;
        rd(REG_SHOW_CTL, 32'h0000_0000, "show ctl");
        rd(8'h10, 32'h0000_0000, "unmapped");
        rd(REG_SHOW_COUNT, 32'h0000_0000, "show count");
        side(2'h2, 1'b0, 1'b0);
        fetch(FK_SEQ);
        chk("hist_flush_status", 32'h2, {30'h0, hist_flush_status});
        fetch(FK_NOT_TAKEN);
        ft(FT_SEQ); // sequential
        side(2'h0, 1'b0, 1'b0);
        ft(FT_NOT_TAKEN); // type follows
        bus(1'b0, 4'h8);
        idle;
        pins(8'he3); // all fetches shown
        wr(REG_SHOW_CTL, 32'h0000_0003);
        rd(REG_STATUS, 32'h0000_0010, "status"); // old value held
        bus(1'b0, 4'h4);
        idle;
        pins(8'hd3); // first fetch under old value
        rd(REG_STATUS, 32'h0000_0003, "status"); // now applied
        bus(1'b0, 4'h4);
        idle;
        pins(8'h01); // nothing shown
        rd(REG_SHOW_COUNT, 32'h0000_0002, "show count");
        wr(REG_SHOW_COUNT, 32'h0000_0000);
        rd(REG_SHOW_COUNT, 32'h0000_0000, "show count");
        side(2'h0, 1'b0, 1'b1);
        idle;
        ft(FT_SYNC); // toggle reported
        chk("sync_force", 32'h1, {31'h0, sync_force}); // forced sync
        bus(1'b1, 4'h0);
        idle;
        pins(8'h87); // external marked
        side(2'h0, 1'b0, 1'b0);
        idle;
        ft(FT_SYNC); // negation reported
        bus(1'b1, 4'h0);
        idle;
        pins(8'h01); // negated, mark not shown
        wr(REG_SHOW_CTL, 32'h0000_0002);
        bus(1'b0, 4'h4);
        fetch(FK_SEQ);
        fetch(FK_INDIRECT);
        cyc(1'b0, FK_NONE, 3'h2, 1'b0, 1'b0, 4'h4);
        ft(FT_INDIRECT); // indirect taken
        idle;
        ft(3'h2); // two flushed
        bus(1'b0, 4'h4);
        chk("capture flush", 32'h2, {29'h0, last_flush}); // decoded
        idle;
        pins(8'hd2); // internal marked
        fetch(FK_EXCEPTION);
        fetch(FK_NOT_TAKEN);
        ft(FT_EXCEPTION); // exception
        cyc(1'b0, FK_NONE, 3'h6, 1'b0, 1'b0, 4'h4);
        ft(FT_NOT_TAKEN_SLOT); // slot replaced
        idle;
        ft(FLUSH_MAX); // saturated count
        fetch(FK_CONTEXT);
        idle;
        ft(FT_INDIRECT); // context as indirect
        bus(1'b1, 4'h0);
        idle;
        pins(8'h87); // next marked
        fetch(FK_DIRECT);
        idle;
        ft(FT_DIRECT); // direct taken
        bus(1'b0, 4'h4);
        idle;
        pins(8'h01); // direct hidden
        side(2'h1, 1'b1, 1'b0);
        idle;
        ft(FT_NONE); // debug type low
        chk("hist_flush_status", 32'h3, {30'h0, hist_flush_status});
        side(2'h0, 1'b0, 1'b0);
        repeat (3) idle;
        complete_run;
    end
endmodule
